// file: pciu_assertions.sv
// Purpose: port checks for pciu_top
// Assumes: one clock, synchronous reset
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
module pciu_assertions
(
  input wire logic                clk,
  input wire logic                rstn,
  input wire pciu_pkg::pciu_req_s req,
  input wire logic [7:0]          rdata,
  input wire logic                global_int_enable,
  input wire logic [23:0]         watched_pin_n,
  input wire logic [2:0]          vector_ack,
  input wire logic [2:0]          group_vector_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_rd(a); req.rd && !req.io_space && req.addr == a; endsequence
  // a change at either edge may set the flag again, so only quiet acks count
  sequence s_ack(k, p); k && $stable(p) ##1 $stable(p); endsequence
  a_need_global: assert property (|group_vector_req |-> $past(global_int_enable))
    else $error("req without global");
  a_ack0_drop: assert property (s_ack(vector_ack[0], watched_pin_n[7:0])
    |-> !group_vector_req[0]) else $error("ack 0 kept");
  a_ack1_drop: assert property (s_ack(vector_ack[1], watched_pin_n[14:8])
    |-> !group_vector_req[1]) else $error("ack 1 kept");
  a_ack2_drop: assert property (s_ack(vector_ack[2], watched_pin_n[23:16])
    |-> !group_vector_req[2]) else $error("ack 2 kept");
  a_rdata_holds: assert property (!$past(req.rd) |-> $stable(rdata))
    else $error("rdata moved");
  a_io_limit: assert property (req.rd && req.io_space && req.addr > 8'h3f
    |=> rdata == 8'h00) else $error("io decode");
  a_flag_top: assert property (s_rd(8'h3b) |=> rdata[7:3] == 5'h00)
    else $error("flag top");
  a_mask1_top: assert property (s_rd(8'h6c) |=> !rdata[7]) else $error("mask1 top");
endmodule

bind pciu_top pciu_assertions u_chk (.clk, .rstn, .req, .rdata, .global_int_enable,
  .watched_pin_n, .vector_ack, .group_vector_req);

// file: pciu_pins.sv
// Purpose: external pins of the three groups
// Assumes: bench asks for toggles one cycle at a time
// Notes:   pins move on the falling edge, clear of sampling
`timescale 1ns/1ps
module pciu_pins
(
  input  wire logic        clk,
  input  wire logic [23:0] flip,
  output logic      [23:0] pins
);
  initial pins = 24'h000000;
  always @(negedge clk) pins <= pins ^ flip;
endmodule

// file: pciu_pkg.sv
// Purpose: constants and types for the pin change interrupt unit
// Assumes: cpu register port with separate rd and wr strobes and an i/o space select
// Notes:   offsets are data-space unless named as i/o
// Behaviour
// - group 2 change raises group 2 interrupt
// - group 1 change raises group 1 interrupt
// - group 0 change raises group 0 interrupt
// - each group requests its own vector
// - change sets group flag, bits 2..0
// - vector only when flag, enable, global set
// - flag clears when its routine starts
// - writing one clears flag, zero keeps
// - group 2 mask at 0x6d, per-pin enables
// - group 1 mask at 0x6c, bit 7 absent
// - group 0 mask at 0x6b, eight enables
// - flag register at 0x3b and i/o 0x1b
// - short i/o address is data minus 0x20
// - group enable register at 0x68, bits 2..0
package pciu_pkg;
  localparam logic [7:0] FLAGS_OFS      = 8'h3b;
  localparam logic [7:0] IO_BIAS        = 8'h20;
  localparam logic [7:0] IO_LAST        = 8'h3f;
  localparam logic [7:0] GROUP_EN_OFS   = 8'h68;
  localparam logic [7:0] MASK0_OFS      = 8'h6b;
  localparam logic [7:0] MASK1_OFS      = 8'h6c;
  localparam logic [7:0] MASK2_OFS      = 8'h6d;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [2:0] GROUP_BITS     = 3'h7;
  localparam logic [7:0] MASK0_BITS     = 8'hff;
  localparam logic [7:0] MASK1_BITS     = 8'h7f;
  localparam logic [7:0] MASK2_BITS     = 8'hff;
  localparam int         NUM_GROUPS     = 3;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       io_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pciu_req_s;

  typedef struct packed {
    logic [2:0] enable;
    logic [2:0] flag;
    logic [7:0] mask0;
    logic [7:0] mask1;
    logic [7:0] mask2;
  } pciu_regs_s;
endpackage

// file: pciu_top.sv
// Purpose: pin change interrupt unit, three groups of watched pins
// Assumes: pins synchronous to clk; cpu acknowledges a vector with a one-cycle pulse
// Notes:   read data is registered, valid the cycle after the read strobe
`timescale 1ns/1ps
module pciu_top
(
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire pciu_pkg::pciu_req_s req,
  output logic [7:0]               rdata,
  input  wire logic                global_int_enable,
  input  wire logic [23:0]         watched_pin_n,
  input  wire logic [2:0]          vector_ack,
  output logic [2:0]               group_vector_req
);
  pciu_pkg::pciu_regs_s regs_q;
  pciu_pkg::pciu_regs_s regs_d;
  logic [23:0]          pin_prev_q;
  logic [23:0]          pin_prev_d;
  logic                 primed_q;
  logic                 primed_d;
  logic [7:0]           rdata_q;
  logic [7:0]           rdata_d;
  logic [2:0]           vreq_q;
  logic [2:0]           vreq_d;
  logic [7:0]           daddr;
  logic                 wr_flags;
  logic                 wr_enable;
  logic [2:0]           wr_mask;
  logic                 rd_flags;
  logic                 rd_enable;
  logic [2:0]           rd_mask;
  logic [23:0]          mask_all;
  logic [23:0]          pin_diff;
  logic [2:0]           change;
  logic [2:0]           flag_clear;
  logic [2:0]           arm;

  // short i/o space maps into data space with the fixed bias; beyond 0x3f nothing decodes
  function automatic logic [7:0] to_data_addr(input pciu_pkg::pciu_req_s r);
    logic [7:0] biased;
    biased = 8'(r.addr + pciu_pkg::IO_BIAS);
    if (!r.io_space)
    begin
      return r.addr;
    end
    // the extended registers sit above the i/o window, so an i/o access never reaches them
    if (r.addr > pciu_pkg::IO_LAST)
    begin
      return 8'h00;
    end
    return biased;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic [7:0] mask_ofs(input int grp);
    logic [7:0] ofs;
    case (grp)
      0:       ofs = pciu_pkg::MASK0_OFS;
      1:       ofs = pciu_pkg::MASK1_OFS;
      default: ofs = pciu_pkg::MASK2_OFS;
    endcase
    return ofs;
  endfunction

  function automatic logic [7:0] mask_bits(input int grp);
    logic [7:0] bits;
    case (grp)
      0:       bits = pciu_pkg::MASK0_BITS;
      1:       bits = pciu_pkg::MASK1_BITS;
      default: bits = pciu_pkg::MASK2_BITS;
    endcase
    return bits;
  endfunction

  function automatic logic [7:0] mask_of(input pciu_pkg::pciu_regs_s r, input int grp);
    logic [7:0] m;
    case (grp)
      0:       m = r.mask0;
      1:       m = r.mask1;
      default: m = r.mask2;
    endcase
    return m;
  endfunction

  // a selected write replaces the field; unimplemented bits stay zero whatever is written
  function automatic logic [7:0] field_write(input logic [7:0] old,
                                             input logic       sel,
                                             input logic [7:0] wdata,
                                             input logic [7:0] bits);
    logic [7:0] nxt;
    nxt = old;
    if (sel)
    begin
      nxt = wdata & bits;
    end
    return nxt;
  endfunction

  assign daddr     = to_data_addr(req);
  assign wr_flags  = req.wr & hit(daddr, pciu_pkg::FLAGS_OFS);
  assign wr_enable = req.wr & hit(daddr, pciu_pkg::GROUP_EN_OFS);
  assign rd_flags  = req.rd & hit(daddr, pciu_pkg::FLAGS_OFS);
  assign rd_enable = req.rd & hit(daddr, pciu_pkg::GROUP_EN_OFS);

  // group 1 occupies pins 14:8 only; pin 15 has no mask bit so it never counts
  genvar g;
  generate
    for (g = 0; g < pciu_pkg::NUM_GROUPS; g++)
    begin : g_group
      assign wr_mask[g]         = req.wr & hit(daddr, mask_ofs(g));
      assign rd_mask[g]         = req.rd & hit(daddr, mask_ofs(g));
      assign mask_all[8*g +: 8] = mask_of(regs_q, g);
      assign pin_diff[8*g +: 8] = watched_pin_n[8*g +: 8] ^ pin_prev_q[8*g +: 8];
      assign change[g]          = primed_q &
                                  (|(pin_diff[8*g +: 8] & mask_all[8*g +: 8]));
      // a one written to the flag bit or the cpu entering the routine clears it
      assign flag_clear[g]      = (wr_flags & req.wdata[g]) | vector_ack[g];
      assign arm[g]             = regs_d.enable[g] & global_int_enable;
    end
  endgenerate

  // register file: masks and group enables follow the cpu, flags follow pins and cpu
  always_comb
  begin
    regs_d       = regs_q;
    regs_d.mask0 = field_write(regs_q.mask0, wr_mask[0], req.wdata, mask_bits(0));
    regs_d.mask1 = field_write(regs_q.mask1, wr_mask[1], req.wdata, mask_bits(1));
    regs_d.mask2 = field_write(regs_q.mask2, wr_mask[2], req.wdata, mask_bits(2));
    if (wr_enable)
    begin
      regs_d.enable = req.wdata[2:0] & pciu_pkg::GROUP_BITS;
    end
    // hardware set comes last so a same-cycle change beats either clear
    regs_d.flag  = (regs_q.flag & ~flag_clear) | change;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      regs_q <= '0;
    end
    else
    begin
      regs_q <= regs_d;
    end
  end

  // the first cycle after reset only primes the previous sample, so reset is no change
  always_comb
  begin
    pin_prev_d = watched_pin_n;
    primed_d   = 1'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pin_prev_q <= 24'h000000;
      primed_q   <= 1'h0;
    end
    else
    begin
      pin_prev_q <= pin_prev_d;
      primed_q   <= primed_d;
    end
  end

  // read data is held until the next read; unmapped addresses read zero
  always_comb
  begin
    rdata_d = rdata_q;
    if (req.rd)
    begin
      rdata_d = 8'h00;
      if (rd_flags)
      begin
        rdata_d = {5'h00, regs_q.flag};
      end
      if (rd_enable)
      begin
        rdata_d = {5'h00, regs_q.enable};
      end
      for (int i = 0; i < pciu_pkg::NUM_GROUPS; i++)
      begin
        if (rd_mask[i])
        begin
          rdata_d = mask_all[8*i +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rdata_q <= pciu_pkg::REG_RESET;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // one request line per group, so the cpu tells the sources apart; an ack drops the line
  // at once so the same flag cannot vector twice
  always_comb
  begin
    vreq_d = regs_d.flag & arm & ~vector_ack;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      vreq_q <= 3'h0;
    end
    else
    begin
      vreq_q <= vreq_d;
    end
  end

  assign rdata            = rdata_q;
  assign group_vector_req = vreq_q;
endmodule

// file: test_pin_change_interrupt_unit.sv
// Purpose: self-checking bench for pciu_top
// Assumes: inputs change on the falling edge
// Notes:   seeded random pins, groups and enables
`timescale 1ns/1ps
module test_pin_change_interrupt_unit;
  logic                clk = 0, rstn = 0, glob = 0;
  pciu_pkg::pciu_req_s req = '0;
  logic [23:0]         pins, flip = 0;
  logic [7:0]          rdata, v;
  logic [7:0]          ofs [5] = '{8'h68, 8'h6b, 8'h6c, 8'h6d, 8'h3b};
  logic [7:0]          bm [5] = '{8'h07, 8'hff, 8'h7f, 8'hff, 8'h00};
  logic [2:0]          ack = 0, vreq, en = 3'h7;
  int                  corner [6] = '{0, 7, 8, 14, 15, 23};
  int                  err_count = 0, n_checks = 0, g;
  initial forever #5 clk = ~clk;
  pciu_top DUT (.clk, .rstn, .req, .rdata, .global_int_enable(glob), .watched_pin_n(pins),
    .vector_ack(ack), .group_vector_req(vreq));
  pciu_pins u_pins (.clk, .flip, .pins);
  task chk(string n, logic [7:0] s, e);
    n_checks++;
    if (s !== e) $display("MISMATCH %s exp %h seen %h", n, e, s);
    if (s !== e) err_count++;
  endtask
  task acc(logic w, io, logic [7:0] a, d);
    @(negedge clk) req = '{!w, w, io, a, d};
    @(negedge clk) req = '0;
  endtask
  // flag bit a toggle on this pin must set; pin 15 has no mask bit behind it
  function automatic logic [7:0] exp_flag(int pin);
    return (pin == 15) ? 8'h00 : 8'h01 << (pin / 8);
  endfunction
  // one toggle on a pin, then the vector, the flag and both ways of clearing it
  task pulse(int pin);
    glob = $urandom % 2;
    v = exp_flag(pin);
    flip <= 24'h1 << pin;
    @(negedge clk) flip <= 24'h0;
    @(negedge clk) chk("vec", vreq, glob ? v & en : 8'h00);
    acc(1'h0, pin[0], pin[0] ? 8'h1b : 8'h3b, 8'h00);
    chk("flag", rdata, v);
    ack = glob ? v[2:0] & en : 3'h0;
    @(negedge clk) ack = 3'h0;
    acc(1'h1, 1'h1, 8'h1b, ~v & 8'h07);
    acc(1'h0, 1'h0, 8'h3b, 8'h00);
    chk("keep", rdata, glob ? v & ~{5'h00, en} : v);
    acc(1'h1, 1'h0, 8'h3b, v);
    acc(1'h0, 1'h1, 8'h1b, 8'h00);
    chk("clear", rdata, 8'h00);
  endtask
  task wrap_up;
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    v = $urandom(32'h354fd078);
    repeat (12) @(negedge clk);
    rstn = 1;
    for (g = 0; g < 5; g++)
    begin
      acc(0, 0, ofs[g], 0);
      chk("reset", rdata, 0);
      v = $urandom;
      acc(1, 0, ofs[g], v);
      acc(0, 0, ofs[g], 0);
      chk("rw", rdata, v & bm[g]);
      acc(1, 0, ofs[g], 8'hff);
    end
    acc(1'h0, 1'h0, 8'h6b, 8'h00);
    chk("mask0", rdata, 8'hff);
    acc(1'h0, 1'h1, 8'h4b, 8'h00);
    chk("io ext", rdata, 8'h00);
    foreach (corner[i])
      pulse(corner[i]);
    repeat (16)
      pulse($urandom % 24);
    // group 1 disarmed: its flag still sets, its vector must stay quiet
    en = 3'h5;
    acc(1'h1, 1'h0, 8'h68, {5'h00, en});
    repeat (8)
      pulse($urandom % 24);
    wrap_up;
  end
endmodule
